// ===== design/word_write_pkg.sv
// Purpose: Shared constants and types for the 16-bit word write external bus.
// Assumes: System clock of 250 MHz (4 ns period).
// Notes:   Phase lengths are derived from times in ns, rounded up to whole cycles.

package word_write_pkg;

	// ********************************************************************
	// Clock and phase timing
	// ********************************************************************
	localparam int CLK_PERIOD_PS = 4000;    // 250 MHz system clock
	localparam int ADDR_PHASE_NS = 8;       // Address and latch enable time
	localparam int STROBE_NS     = 16;      // Write strobe low time
	localparam int READ_NS       = 24;      // Output enable time for reads

	localparam int ADDR_CYCLES   = (ADDR_PHASE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int STROBE_CYCLES = (STROBE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int READ_CYCLES   = (READ_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	// Least read time that covers the pin synchroniser latency
	localparam int MIN_READ_CYCLES = 4;

	// ********************************************************************
	// Widths, field positions and reset values
	// ********************************************************************
	localparam int PTR_W       = 21;        // Table pointer width
	localparam int PTR_LSB_POS = 0;         // Byte select bit of the pointer
	localparam int CNT_W       = 4;         // Phase counter width
	localparam logic [7:0] HOLD_RESET = 8'h00;

	// ********************************************************************
	// Operation kinds and bus states
	// ********************************************************************
	typedef enum logic [1:0] {
		OP_FETCH     = 2'b00,               // Opcode fetch, 16-bit read
		OP_TBL_READ  = 2'b01,               // Table read, 16-bit read
		OP_TBL_WRITE = 2'b10,               // Table write of one byte
		OP_SPARE     = 2'b11                // Treated as a read
	} op_kind_e;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_ADDR   = 3'b001,
		ST_TURN   = 3'b010,
		ST_ACTIVE = 3'b011,
		ST_HOLD   = 3'b100
	} bus_state_e;

endpackage : word_write_pkg

// ===== design/pin_sync.sv
// Purpose: Three-stage synchroniser for bus pins with agreement filter.
// Assumes: Inputs are asynchronous to the clock.
// Notes:   A bit changes only when the second and third stages agree.

`timescale 1ns/100ps

module pin_sync #(
	parameter int WIDTH = 16
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);

	logic [WIDTH-1:0] s1_reg;
	logic [WIDTH-1:0] s2_reg;
	logic [WIDTH-1:0] s3_reg;
	logic [WIDTH-1:0] q_reg;
	logic [WIDTH-1:0] agree;

	// ********************************************************************
	// Agreement filter
	// ********************************************************************
	assign agree = ~(s2_reg ^ s3_reg);
	assign q     = q_reg;

	// Stage chain; the first stage feeds only the second
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
			q_reg  <= '0;
		end else begin
			s1_reg <= d;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			q_reg  <= (agree & s3_reg) | (~agree & q_reg);
		end
	end

endmodule : pin_sync

// ===== design/word_write_bus.sv
// Purpose: Multiplexed 16-bit external bus in word write mode: fetches,
//          table reads, and paired byte table writes merged into words.
// Assumes: One request at a time; pin inputs are asynchronous.
// Notes:   All pin outputs except WRITE_LOW_STROBE_N (tied high) are registered and follow the bus state.
//
// Notes on behaviour
// - Odd write drives latch byte upper
// - Odd write drives held byte lower
// - High strobe pulses per odd write, low idle
// - Byte address pin shows pointer bit zero
// - Word write asserts both byte selects
// - Even write loads holding latch; runs address phase, no strobe
// - Supports fetches and table reads too

`timescale 1ns/100ps

module word_write_bus #(
	parameter int ADDR_CYCLES   = word_write_pkg::ADDR_CYCLES,
	parameter int STROBE_CYCLES = word_write_pkg::STROBE_CYCLES,
	parameter int READ_CYCLES   = word_write_pkg::READ_CYCLES
) (
	input  wire logic        SYS_CLK,
	input  wire logic        RST,
	input  wire logic        REQ_VALID,
	output logic             REQ_READY,
	input  wire logic [1:0]  REQ_KIND,
	input  wire logic [20:0] TABLE_POINTER,
	input  wire logic [7:0]  TABLE_DATA_LATCH,
	output logic             RSP_VALID,
	output logic [15:0]      RSP_DATA,
	input  wire logic [15:0] MUXED_ADDR_DATA_BUS_IN,
	output logic [15:0]      MUXED_ADDR_DATA_BUS_OUT,
	output logic             MUXED_ADDR_DATA_BUS_OE,
	output logic [3:0]       UPPER_ADDR,
	output logic             ADDR_LATCH_EN,
	output logic             OUTPUT_ENABLE_N,
	output logic             WRITE_HIGH_STROBE_N,
	output logic             WRITE_LOW_STROBE_N,
	output logic             BYTE_ADDR_LSB_PIN,
	output logic             UPPER_BYTE_SELECT_N,
	output logic             LOWER_BYTE_SELECT_N
);

	// ********************************************************************
	// Elaboration checks
	// ********************************************************************
	if (ADDR_CYCLES < 1 || ADDR_CYCLES > 15) begin : g_bad_addr
		$error("ADDR_CYCLES out of range 1..15");
	end
	if (STROBE_CYCLES < 1 || STROBE_CYCLES > 15) begin : g_bad_strobe
		$error("STROBE_CYCLES out of range 1..15");
	end
	if (READ_CYCLES < word_write_pkg::MIN_READ_CYCLES || READ_CYCLES > 15) begin : g_bad_read
		$error("READ_CYCLES out of range 4..15");
	end

	localparam logic [3:0] ADDR_LEN   = 4'(ADDR_CYCLES - 1);
	localparam logic [3:0] STROBE_LEN = 4'(STROBE_CYCLES - 1);
	localparam logic [3:0] READ_LEN   = 4'(READ_CYCLES - 1);

	// ********************************************************************
	// State and request holding registers
	// ********************************************************************
	word_write_pkg::bus_state_e       state_reg;
	word_write_pkg::bus_state_e       state_next;
	logic [word_write_pkg::CNT_W-1:0] cnt_reg;
	logic [word_write_pkg::CNT_W-1:0] cnt_next;
	logic [1:0]                       kind_reg;
	logic [20:0]                      ptr_reg;
	logic [7:0]                       data_reg;
	logic [7:0]                       hold_reg;
	logic [15:0]                      bus_in_sync;

	// Registered pin and answer outputs
	logic [15:0] ad_reg;
	logic        ad_oe_reg;
	logic [3:0]  upper_reg;
	logic        ale_reg;
	logic        oe_n_reg;
	logic        wrh_n_reg;
	logic        ba0_reg;
	logic        sel_n_reg;
	logic        rsp_valid_reg;
	logic [15:0] rsp_data_reg;

	// ********************************************************************
	// Request decode
	// ********************************************************************
	logic        accept;
	logic        last;
	logic [1:0]  cur_kind;
	logic [20:0] cur_ptr;
	logic [7:0]  cur_data;
	logic        cur_write;
	logic        cur_odd;
	logic        even_load;
	logic [3:0]  active_len;
	logic        next_busy;
	logic        next_data;

	assign REQ_READY  = (state_reg == word_write_pkg::ST_IDLE);
	assign accept     = REQ_VALID && REQ_READY;
	assign last       = (cnt_reg == '0);
	assign cur_kind   = accept ? REQ_KIND : kind_reg;
	assign cur_ptr    = accept ? TABLE_POINTER : ptr_reg;
	assign cur_data   = accept ? TABLE_DATA_LATCH : data_reg;
	assign cur_write  = (cur_kind == word_write_pkg::OP_TBL_WRITE);
	assign cur_odd    = cur_ptr[word_write_pkg::PTR_LSB_POS];
	assign even_load  = accept && cur_write && !cur_odd;
	assign active_len = cur_write ? STROBE_LEN : READ_LEN;

	// Bus cycle sequencing
	always_comb begin
		state_next = state_reg;
		cnt_next   = last ? cnt_reg : cnt_reg - 4'h1;
		case (state_reg)
			word_write_pkg::ST_IDLE: begin
				if (accept) begin
					state_next = word_write_pkg::ST_ADDR;
					cnt_next   = ADDR_LEN;
				end
			end
			word_write_pkg::ST_ADDR: begin
				if (last) begin
					state_next = word_write_pkg::ST_TURN;
				end
			end
			word_write_pkg::ST_TURN: begin
				state_next = word_write_pkg::ST_ACTIVE;
				cnt_next   = active_len;
			end
			word_write_pkg::ST_ACTIVE: begin
				if (last) begin
					state_next = word_write_pkg::ST_HOLD;
				end
			end
			word_write_pkg::ST_HOLD: begin
				state_next = word_write_pkg::ST_IDLE;
			end
			default: begin
				state_next = word_write_pkg::ST_IDLE;
				cnt_next   = '0;
			end
		endcase
	end

	// ********************************************************************
	// Next pin values, taken from the next state
	// ********************************************************************
	logic        ale_next;
	logic        ad_oe_next;
	logic [15:0] ad_next;
	logic        wrh_n_next;
	logic        sel_n_next;
	logic        oe_n_next;

	assign next_busy  = (state_next != word_write_pkg::ST_IDLE);
	assign next_data  = next_busy && (state_next != word_write_pkg::ST_ADDR);
	assign ale_next   = (state_next == word_write_pkg::ST_ADDR);
	assign ad_oe_next = ale_next || (next_data && cur_write && cur_odd);
	assign ad_next    = ale_next ? cur_ptr[16:1] : {cur_data, hold_reg};
	assign wrh_n_next = !((state_next == word_write_pkg::ST_ACTIVE) && cur_write && cur_odd);
	assign sel_n_next = !(next_data && (!cur_write || cur_odd));
	assign oe_n_next  = !((state_next == word_write_pkg::ST_ACTIVE) && !cur_write);

	// State, counter and request capture
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			state_reg <= word_write_pkg::ST_IDLE;
			cnt_reg   <= '0;
			kind_reg  <= word_write_pkg::OP_FETCH;
			ptr_reg   <= '0;
			data_reg  <= '0;
		end else begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
			kind_reg  <= cur_kind;
			ptr_reg   <= cur_ptr;
			data_reg  <= cur_data;
		end
	end

	// Holding latch, loaded only by even-address writes
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			hold_reg <= word_write_pkg::HOLD_RESET;
		end else if (even_load) begin
			hold_reg <= TABLE_DATA_LATCH;
		end
	end

	// Pin output registers
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			ad_reg    <= '0;
			ad_oe_reg <= 1'b0;
			upper_reg <= '0;
			ale_reg   <= 1'b0;
			oe_n_reg  <= 1'b1;
			wrh_n_reg <= 1'b1;
			ba0_reg   <= 1'b0;
			sel_n_reg <= 1'b1;
		end else begin
			ad_reg    <= ad_next;
			ad_oe_reg <= ad_oe_next;
			upper_reg <= next_busy ? cur_ptr[20:17] : 4'h0;
			ale_reg   <= ale_next;
			oe_n_reg  <= oe_n_next;
			wrh_n_reg <= wrh_n_next;
			ba0_reg   <= next_busy && cur_odd;
			sel_n_reg <= sel_n_next;
		end
	end

	// Completion pulse and read data capture
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			rsp_valid_reg <= 1'b0;
			rsp_data_reg  <= '0;
		end else begin
			rsp_valid_reg <= (state_reg == word_write_pkg::ST_ACTIVE) && last;
			if ((state_reg == word_write_pkg::ST_ACTIVE) && last && !cur_write) begin
				rsp_data_reg <= bus_in_sync;
			end
		end
	end

	// Data bus input synchroniser
	pin_sync #(
		.WIDTH (16)
	) u_bus_sync (
		.clk (SYS_CLK),
		.rst (RST),
		.d   (MUXED_ADDR_DATA_BUS_IN),
		.q   (bus_in_sync)
	);

	// ********************************************************************
	// Output wiring
	// ********************************************************************
	assign MUXED_ADDR_DATA_BUS_OUT = ad_reg;
	assign MUXED_ADDR_DATA_BUS_OE  = ad_oe_reg;
	assign UPPER_ADDR              = upper_reg;
	assign ADDR_LATCH_EN           = ale_reg;
	assign OUTPUT_ENABLE_N         = oe_n_reg;
	assign WRITE_HIGH_STROBE_N     = wrh_n_reg;
	assign WRITE_LOW_STROBE_N      = 1'b1;
	assign BYTE_ADDR_LSB_PIN       = ba0_reg;
	assign UPPER_BYTE_SELECT_N     = sel_n_reg;
	assign LOWER_BYTE_SELECT_N     = sel_n_reg;
	assign RSP_VALID               = rsp_valid_reg;
	assign RSP_DATA                = rsp_data_reg;

	// ********************************************************************
	// Assertions
	// ********************************************************************
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (RST);

	logic       odd_wr_phase;
	logic [3:0] strobe_len_reg;

	assign odd_wr_phase = (state_reg == word_write_pkg::ST_ACTIVE) && ptr_reg[0]
		&& (kind_reg == word_write_pkg::OP_TBL_WRITE);

	// Counts the low time of the high write strobe
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			strobe_len_reg <= '0;
		end else begin
			strobe_len_reg <= WRITE_HIGH_STROBE_N ? 4'h0 : strobe_len_reg + 4'h1;
		end
	end

	property p_odd_upper;
		odd_wr_phase |-> MUXED_ADDR_DATA_BUS_OE && (MUXED_ADDR_DATA_BUS_OUT[15:8] == data_reg);
	endproperty
	a_odd_upper: assert property (p_odd_upper) else $error("Odd write upper byte wrong");

	property p_odd_lower;
		odd_wr_phase |-> (MUXED_ADDR_DATA_BUS_OUT[7:0] == hold_reg);
	endproperty
	a_odd_lower: assert property (p_odd_lower) else $error("Odd write lower byte wrong");

	// Low strobe never moves; high strobe only inside an odd write data phase
	property p_low_strobe_idle;
		WRITE_LOW_STROBE_N && (WRITE_HIGH_STROBE_N || odd_wr_phase);
	endproperty
	a_low_strobe_idle: assert property (p_low_strobe_idle) else $error("Strobe misuse");

	property p_strobe_width;
		$rose(WRITE_HIGH_STROBE_N) |-> (strobe_len_reg == 4'(STROBE_CYCLES));
	endproperty
	a_strobe_width: assert property (p_strobe_width) else $error("Strobe width wrong");

	property p_ba0;
		(state_reg != word_write_pkg::ST_IDLE) |-> (BYTE_ADDR_LSB_PIN == ptr_reg[0]);
	endproperty
	a_ba0: assert property (p_ba0) else $error("Byte address pin wrong");

	property p_both_sel;
		!WRITE_HIGH_STROBE_N |-> !UPPER_BYTE_SELECT_N && !LOWER_BYTE_SELECT_N;
	endproperty
	a_both_sel: assert property (p_both_sel) else $error("Byte selects not both active");

	property p_even_quiet;
		accept && (REQ_KIND == word_write_pkg::OP_TBL_WRITE) && !TABLE_POINTER[0]
		|=> (hold_reg == $past(TABLE_DATA_LATCH))
		##[1:20] (state_reg == word_write_pkg::ST_ACTIVE) && !MUXED_ADDR_DATA_BUS_OE
			&& WRITE_HIGH_STROBE_N;
	endproperty
	a_even_quiet: assert property (p_even_quiet) else $error("Even write not quiet");

	property p_read_done;
		accept && (REQ_KIND != word_write_pkg::OP_TBL_WRITE)
		|-> ##[4:40] !OUTPUT_ENABLE_N ##[1:20] RSP_VALID;
	endproperty
	a_read_done: assert property (p_read_done) else $error("Read did not complete");

	property p_hold_keep;
		!even_load |=> $stable(hold_reg);
	endproperty
	a_hold_keep: assert property (p_hold_keep) else $error("Holding latch changed");

	c_even_write: cover property (even_load ##[1:30] RSP_VALID);
	c_odd_write:  cover property ($fell(WRITE_HIGH_STROBE_N) ##[1:20] RSP_VALID);
	c_read:       cover property ($fell(OUTPUT_ENABLE_N) ##[1:20] RSP_VALID);
	c_pair:       cover property (even_load ##[1:30] $fell(WRITE_HIGH_STROBE_N));

endmodule : word_write_bus

// ===== verification/ext_word_memory.sv
// Purpose: Behavioural word-wide external memory on the multiplexed bus.
// Assumes: Word address latched while the latch enable is high.
// Notes:   A released bus shows the inverse of its last level, changing each cycle.

`timescale 1ns/100ps

module ext_word_memory (
	input  wire logic        clk,
	input  wire logic [15:0] bus_out,
	input  wire logic        bus_oe,
	input  wire logic        ale,
	input  wire logic        oe_n,
	input  wire logic        wrh_n,
	input  wire logic        ub_n,
	input  wire logic        lb_n,
	output logic      [15:0] bus_in
);
	logic [15:0] mem [0:255];
	logic [7:0]  addr_reg;
	logic [15:0] last_reg = 16'h5a5a;

	// Wire level: device drive, memory output, else a flipping pattern
	assign bus_in = bus_oe ? bus_out : (!oe_n ? mem[addr_reg] : ~last_reg);

	// Latch the word address, store the word while strobe and both selects are low
	always @(posedge clk) begin
		last_reg <= bus_in;
		if (ale && bus_oe) begin
			addr_reg <= bus_out[7:0];
		end
		if (!wrh_n && !ub_n && !lb_n && bus_oe) begin
			mem[addr_reg] <= bus_out;
		end
	end
endmodule : ext_word_memory

// ===== verification/word_write_bus_bench.sv
// Purpose: Self-checking bench for the word write external bus.
// Assumes: Default phase lengths from the package.
// Notes:   Each operation is watched cycle by cycle at the falling edge.

`timescale 1ns/100ps

module word_write_bus_bench;
	localparam int WR_LAT = word_write_pkg::ADDR_CYCLES + word_write_pkg::STROBE_CYCLES + 2;
	localparam int RD_LAT = word_write_pkg::ADDR_CYCLES + word_write_pkg::READ_CYCLES + 2;
	logic        sys_clk, rst, req_valid, req_ready, rsp_valid, ale, oe_n, wrh_n, wrl_n;
	logic        ba0, ub_n, lb_n, bus_oe;
	logic [1:0]  req_kind;
	logic [20:0] table_pointer;
	logic [7:0]  table_data;
	logic [15:0] rsp_data, bus_in, bus_out, m_bus;
	int          error_cnt, check_count, m_strobe, m_drive, m_sel, m_sel_str, m_wrl, m_lat;
	logic        m_ba0;
	logic [3:0]  upper, m_up;

	word_write_bus #(.ADDR_CYCLES(word_write_pkg::ADDR_CYCLES),
		.STROBE_CYCLES(word_write_pkg::STROBE_CYCLES),
		.READ_CYCLES(word_write_pkg::READ_CYCLES)) dut (
		.SYS_CLK(sys_clk), .RST(rst), .REQ_VALID(req_valid), .REQ_READY(req_ready),
		.REQ_KIND(req_kind), .TABLE_POINTER(table_pointer), .TABLE_DATA_LATCH(table_data),
		.RSP_VALID(rsp_valid), .RSP_DATA(rsp_data), .MUXED_ADDR_DATA_BUS_IN(bus_in),
		.MUXED_ADDR_DATA_BUS_OUT(bus_out), .MUXED_ADDR_DATA_BUS_OE(bus_oe), .UPPER_ADDR(upper),
		.ADDR_LATCH_EN(ale), .OUTPUT_ENABLE_N(oe_n), .WRITE_HIGH_STROBE_N(wrh_n),
		.WRITE_LOW_STROBE_N(wrl_n), .BYTE_ADDR_LSB_PIN(ba0),
		.UPPER_BYTE_SELECT_N(ub_n), .LOWER_BYTE_SELECT_N(lb_n));

	ext_word_memory mem (.clk(sys_clk), .bus_out(bus_out), .bus_oe(bus_oe), .ale(ale),
		.oe_n(oe_n), .wrh_n(wrh_n), .ub_n(ub_n), .lb_n(lb_n), .bus_in(bus_in));

	// Clock generator, 4 ns period
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	// ********************************************************************
	// Shared tasks
	// ********************************************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic tally_and_finish;
		$display("Checks %0d, mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : tally_and_finish

	// One request, watched until its completion pulse; entered just after a rising edge
	task automatic op(input logic [1:0] kind, input logic [20:0] ptr, input logic [7:0] dat);
		logic seen_ale;
		seen_ale = 1'b0;
		{m_strobe, m_drive, m_sel, m_sel_str, m_wrl, m_lat} = '0;
		req_valid     <= 1'b1;
		req_kind      <= kind;
		table_pointer <= ptr;
		table_data    <= dat;
		@(negedge sys_clk);
		while (!req_ready) @(negedge sys_clk);
		@(posedge sys_clk);
		req_valid <= 1'b0;
		do begin
			@(negedge sys_clk);
			m_lat++;
			if (ale) begin
				seen_ale = 1'b1;
				m_up     = upper;
			end
			if (seen_ale && !ale && bus_oe) m_drive++;
			if (!ub_n || !lb_n) m_sel++;
			if (!wrl_n) m_wrl++;
			if (!wrh_n) begin
				m_strobe++;
				m_bus = bus_out;
				m_ba0 = ba0;
				if (!ub_n && !lb_n) m_sel_str++;
			end
		end while (!rsp_valid && m_lat < 40);
		check(m_wrl, 0);
		@(posedge sys_clk);
	endtask : op

	task automatic write_even(input logic [20:0] ptr, input logic [7:0] lo);
		op(2'b10, ptr, lo);
		check(m_strobe, 0);
		check(m_drive, 0);
		check(m_sel, 0);
		check(m_lat, WR_LAT);
	endtask : write_even

	task automatic write_odd(input logic [20:0] ptr, input logic [7:0] hi,
		input logic [15:0] exp);
		op(2'b10, ptr, hi);
		check(m_bus, exp);
		check(m_strobe, word_write_pkg::STROBE_CYCLES);
		check(m_ba0, 1'b1);
		check(m_sel_str, word_write_pkg::STROBE_CYCLES);
		check(m_drive, word_write_pkg::STROBE_CYCLES + 2);
		check(m_lat, WR_LAT);
	endtask : write_odd

	task automatic read_word(input logic [1:0] kind, input logic [20:0] ptr,
		input logic [15:0] exp);
		op(kind, ptr, 8'h00);
		check(rsp_data, exp);
		check(m_strobe, 0);
		check(m_lat, RD_LAT);
		check(m_up, ptr[20:17]);
	endtask : read_word

	// ********************************************************************
	// Scenarios
	// ********************************************************************
	task automatic t_pairs;
		logic [1:0] kinds [3];
		kinds = '{2'b00, 2'b01, 2'b11};
		write_even(21'h000100, 8'ha5);
		write_odd(21'h000101, 8'h3c, 16'h3ca5);
		write_even(21'h1ffffe, 8'h0f);
		write_odd(21'h1fffff, 8'hf0, 16'hf00f);
		foreach (kinds[i]) begin
			read_word(kinds[i], 21'h000100, 16'h3ca5);
		end
		read_word(2'b01, 21'h1ffffe, 16'hf00f);
		$display("t_pairs done");
	endtask : t_pairs

	task automatic t_retain;
		write_even(21'h000104, 8'h11);
		read_word(2'b00, 21'h000100, 16'h3ca5);
		write_odd(21'h000105, 8'h22, 16'h2211);
		read_word(2'b01, 21'h000104, 16'h2211);
		$display("t_retain done");
	endtask : t_retain

	task automatic t_reset_clears;
		write_even(21'h000106, 8'h77);
		rst <= 1'b1;
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		@(negedge sys_clk);
		check({wrh_n, wrl_n, ub_n, lb_n, bus_oe}, 5'h1e);
		@(posedge sys_clk);
		write_odd(21'h000107, 8'h88, 16'h8800);
		read_word(2'b01, 21'h000106, 16'h8800);
		$display("t_reset_clears done");
	endtask : t_reset_clears

	// Main sequence: reset for 20 cycles, then the scenarios
	initial begin
		error_cnt     = 0;
		check_count   = 0;
		rst           = 1'b1;
		req_valid     = 1'b0;
		req_kind      = 2'b00;
		table_pointer = 21'h000000;
		table_data    = 8'h00;
		repeat (20) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		t_pairs();
		t_retain();
		t_reset_clears();
		tally_and_finish();
	end

	// Watchdog well beyond the expected run of fewer than 200 cycles
	initial begin
		repeat (5000) @(posedge sys_clk);
		error_cnt++;
		tally_and_finish();
	end
endmodule : word_write_bus_bench
